// [rtl/ewm_ctrl.sv]
// Purpose: two-wire bus master driving a serial memory through its pins
// Assumes: one bus master, pull-up on the data line, scl driven push-pull
// Notes:   single-byte write, random read, current read and ack poll
// Behaviour
// - fixed select pin driven high from reset onward
// - chip-select pins settle before traffic and stay put during it
// - data line changes only while clock low, except start and stop
// - master alone makes clock, start and stop; memory never drives clock
// - start only when both lines have been high
// - data falling with clock high is start; each command opens with one
// - data rising with clock high is stop; each operation closes with one
// - one bit per clock pulse, stable through clock high
// - master chooses byte count between start and stop
// - receiver acknowledges each byte on a ninth clock pulse
// - acknowledge is data held low through the ninth pulse high phase
// - master ends reads with no ack; memory releases data for stop
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`include "ewm_defs.svh"

module ewm_ctrl #(
  parameter int       QUARTER_CYC = `EWM_QUARTER_CYC,
  parameter bit [3:0] DEV_TYPE    = `EWM_DEV_TYPE_DEFAULT // arbitrary value, set per board
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  bus_addr_in,
  input  wire logic [31:0] bus_wdata_in,
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  output logic      [31:0] bus_rdata_out,
  output logic             scl_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             chip_select_pin_low_out,
  output logic             chip_select_pin_high_out,
  output logic             fixed_select_pin_out,
  output logic             write_protect_out
);

  ewm_pkg::ewm_cmd_t   cmd;
  ewm_pkg::ewm_cmd_t   cmd_ff;
  ewm_pkg::ewm_stat_t  stat;
  ewm_pkg::ewm_state_t st_ff;
  ewm_pkg::ewm_phase_t ph_ff;
  ewm_pkg::ewm_phase_t nph;
  logic                go;
  logic                sda_q;
  logic [15:0]         qcnt_ff;
  logic [1:0]          q_ff;
  logic                tick;
  logic                qend;
  logic [2:0]          bit_ff;
  logic [7:0]          sh_ff;
  logic [7:0]          rbyte_ff;
  logic                ack_ff;
  logic                first_ff;
  logic                busy_ff;
  logic                done_pls_ff;
  logic                nack_pls_ff;
  logic                scl_ff;
  logic                sda_oe_ff;
  logic                cond_ff;
  logic                nxt_scl;
  logic                nxt_oe;
  logic                cs_low_ff;
  logic                cs_high_ff;
  logic                fixed_ff;
  logic                wp_ff;
  logic                sda_zero_ff;

  function automatic logic [7:0] ctrl_byte(input ewm_pkg::ewm_sel_t s, input logic rd);
    ctrl_byte = {DEV_TYPE, s.block, s.cs_high, s.cs_low, rd};
  endfunction : ctrl_byte

  function automatic logic [7:0] phase_byte(input ewm_pkg::ewm_phase_t p, input ewm_pkg::ewm_cmd_t c);
    case (p)
      ewm_pkg::PH_CTRL_W: phase_byte = ctrl_byte(c.sel, 1'b0);
      ewm_pkg::PH_CTRL_R: phase_byte = ctrl_byte(c.sel, 1'b1);
      ewm_pkg::PH_AHI:    phase_byte = c.addr[15:8];
      ewm_pkg::PH_ALO:    phase_byte = c.addr[7:0];
      ewm_pkg::PH_DATA:   phase_byte = c.wdata;
      default:            phase_byte = 8'hFF;
    endcase
  endfunction : phase_byte

  // byte sequence per operation; count of bytes is ours to choose
  function automatic ewm_pkg::ewm_phase_t next_phase(input ewm_pkg::ewm_op_t op,
                                                     input ewm_pkg::ewm_phase_t p);
    case (p)
      ewm_pkg::PH_CTRL_W: next_phase = (op == ewm_pkg::EWM_OP_POLL) ? ewm_pkg::PH_END : ewm_pkg::PH_AHI;
      ewm_pkg::PH_AHI:    next_phase = ewm_pkg::PH_ALO;
      ewm_pkg::PH_ALO:    next_phase = (op == ewm_pkg::EWM_OP_WRITE) ? ewm_pkg::PH_DATA : ewm_pkg::PH_RESTART;
      ewm_pkg::PH_CTRL_R: next_phase = ewm_pkg::PH_READ;
      default:            next_phase = ewm_pkg::PH_END;
    endcase
  endfunction : next_phase

  ewm_regs u_regs (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .bus_addr_in   (bus_addr_in),
    .bus_wdata_in  (bus_wdata_in),
    .bus_wr_in     (bus_wr_in),
    .bus_rd_in     (bus_rd_in),
    .bus_rdata_out (bus_rdata_out),
    .stat_in       (stat),
    .cmd_out       (cmd),
    .go_out        (go)
  );

  ewm_sync #(.RESET_VAL(1'b1)) u_sda_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .d_in        (sda_in),
    .q_out       (sda_q)
  );

  assign stat = '{busy: busy_ff, done: done_pls_ff, nack: nack_pls_ff, rdata: rbyte_ff};

  // free-running quarter-bit timer; every bus step lands on a tick
  assign tick = (qcnt_ff == 16'(QUARTER_CYC - 1));
  assign qend = tick && (q_ff == 2'd3);
  assign nph  = next_phase(cmd_ff.op, ph_ff);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      qcnt_ff <= 16'h0000;
      q_ff    <= 2'd0;
    end else if (tick) begin
      qcnt_ff <= 16'h0000;
      q_ff    <= q_ff + 2'd1;
    end else begin
      qcnt_ff <= qcnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_ff       <= ewm_pkg::ST_IDLE;
      ph_ff       <= ewm_pkg::PH_CTRL_W;
      cmd_ff      <= '0;
      bit_ff      <= 3'd7;
      sh_ff       <= 8'h00;
      ack_ff      <= 1'b1;
      first_ff    <= 1'b1;
      busy_ff     <= 1'b0;
      done_pls_ff <= 1'b0;
      nack_pls_ff <= 1'b0;
      rbyte_ff    <= 8'h00;
    end else begin
      done_pls_ff <= 1'b0;
      nack_pls_ff <= 1'b0;
      case (st_ff)
        ewm_pkg::ST_IDLE: begin
          if (go) begin
            cmd_ff   <= cmd;
            busy_ff  <= 1'b1;
            first_ff <= 1'b1;
            ph_ff    <= (cmd.op == ewm_pkg::EWM_OP_CUR_READ) ? ewm_pkg::PH_CTRL_R : ewm_pkg::PH_CTRL_W;
            st_ff    <= ewm_pkg::ST_BUSWAIT;
          end
        end
        ewm_pkg::ST_BUSWAIT: begin
          if (qend && sda_q && scl_ff) begin
            st_ff <= ewm_pkg::ST_START;
          end
        end
        ewm_pkg::ST_START: begin
          if (qend) begin
            sh_ff  <= phase_byte(ph_ff, cmd_ff);
            bit_ff <= 3'd7;
            st_ff  <= ewm_pkg::ST_TXBIT;
          end
        end
        ewm_pkg::ST_TXBIT: begin
          if (qend) begin
            if (bit_ff == 3'd0) begin
              st_ff <= ewm_pkg::ST_TXACK;
            end else begin
              bit_ff <= bit_ff - 3'd1;
              sh_ff  <= {sh_ff[6:0], 1'b0};
            end
          end
        end
        ewm_pkg::ST_TXACK: begin
          if (tick && q_ff == 2'd2) begin
            ack_ff <= sda_q;
          end
          if (qend) begin
            if (ack_ff) begin
              // no ack: mismatch or memory still programming, give up cleanly
              nack_pls_ff <= 1'b1;
              st_ff       <= ewm_pkg::ST_STOP;
            end else if (nph == ewm_pkg::PH_READ) begin
              bit_ff <= 3'd7;
              st_ff  <= ewm_pkg::ST_RXBIT;
            end else if (nph == ewm_pkg::PH_RESTART) begin
              ph_ff    <= ewm_pkg::PH_CTRL_R;
              first_ff <= 1'b0;
              st_ff    <= ewm_pkg::ST_START;
            end else if (nph == ewm_pkg::PH_END) begin
              st_ff <= ewm_pkg::ST_STOP;
            end else begin
              ph_ff  <= nph;
              sh_ff  <= phase_byte(nph, cmd_ff);
              bit_ff <= 3'd7;
              st_ff  <= ewm_pkg::ST_TXBIT;
            end
          end
        end
        ewm_pkg::ST_RXBIT: begin
          if (tick && q_ff == 2'd2) begin
            sh_ff <= {sh_ff[6:0], sda_q};
          end
          if (qend) begin
            if (bit_ff == 3'd0) begin
              st_ff <= ewm_pkg::ST_RXACK;
            end else begin
              bit_ff <= bit_ff - 3'd1;
            end
          end
        end
        ewm_pkg::ST_RXACK: begin
          if (qend) begin
            rbyte_ff <= sh_ff;
            st_ff    <= ewm_pkg::ST_STOP;
          end
        end
        ewm_pkg::ST_STOP: begin
          if (qend) begin
            busy_ff     <= 1'b0;
            done_pls_ff <= 1'b1;
            st_ff       <= ewm_pkg::ST_IDLE;
          end
        end
        default: st_ff <= ewm_pkg::ST_IDLE;
      endcase
    end
  end

  // pin levels from state and quarter; registered so outputs come from flops
  always_comb begin
    nxt_scl = 1'b1;
    nxt_oe  = 1'b0;
    case (st_ff)
      ewm_pkg::ST_START: begin
        nxt_oe  = (q_ff >= 2'd2);
        nxt_scl = first_ff ? (q_ff != 2'd3) : (q_ff == 2'd1 || q_ff == 2'd2);
      end
      ewm_pkg::ST_TXBIT: begin
        nxt_oe  = !sh_ff[7];
        nxt_scl = (q_ff == 2'd1 || q_ff == 2'd2);
      end
      ewm_pkg::ST_TXACK,
      ewm_pkg::ST_RXBIT,
      ewm_pkg::ST_RXACK: begin
        nxt_oe  = 1'b0;
        nxt_scl = (q_ff == 2'd1 || q_ff == 2'd2);
      end
      ewm_pkg::ST_STOP: begin
        nxt_oe  = (q_ff < 2'd2);
        nxt_scl = (q_ff != 2'd0);
      end
      default: begin
        nxt_oe  = 1'b0;
        nxt_scl = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      scl_ff      <= 1'b1;
      sda_oe_ff   <= 1'b0;
      cond_ff     <= 1'b0;
      sda_zero_ff <= 1'b0;
    end else begin
      scl_ff      <= nxt_scl;
      sda_oe_ff   <= nxt_oe;
      cond_ff     <= (st_ff == ewm_pkg::ST_START) || (st_ff == ewm_pkg::ST_STOP);
      sda_zero_ff <= 1'b0;
    end
  end

  // chip-select and write-protect pins copy register settings; settings are frozen while busy
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cs_low_ff  <= 1'b0;
      cs_high_ff <= 1'b0;
      fixed_ff   <= 1'b1;
      wp_ff      <= 1'b0;
    end else begin
      cs_low_ff  <= cmd.sel.cs_low;
      cs_high_ff <= cmd.sel.cs_high;
      fixed_ff   <= 1'b1;
      wp_ff      <= cmd.sel.wp;
    end
  end

  assign scl_out                  = scl_ff;
  assign sda_out                  = sda_zero_ff;
  assign sda_oe_out               = sda_oe_ff;
  assign chip_select_pin_low_out  = cs_low_ff;
  assign chip_select_pin_high_out = cs_high_ff;
  assign fixed_select_pin_out     = fixed_ff;
  assign write_protect_out        = wp_ff;

  localparam int AST_QMAX = 400;
  localparam int AST_SPAN = 1000;

  default clocking ast_cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_start;
    scl_ff && $rose(sda_oe_ff);
  endsequence

  sequence s_stop;
    scl_ff && $fell(sda_oe_ff) && cond_ff;
  endsequence

  AST_FIXED_SEL:
    assert property (!$past(rst_in) |-> fixed_select_pin_out)
    else $error("fixed select pin not high");

  AST_CS_STABLE:
    assert property (busy_ff && $past(busy_ff) |-> $stable({cs_high_ff, cs_low_ff}))
    else $error("chip select moved during transfer");

  AST_WP_STABLE:
    assert property (busy_ff && $past(busy_ff) |-> $stable(wp_ff))
    else $error("write protect moved during transfer");

  AST_DATA_LOW_SCL:
    assert property ($changed(sda_oe_ff) && scl_ff && $past(scl_ff) |-> cond_ff)
    else $error("data changed with clock high outside start or stop");

  AST_SCL_IDLE:
    assert property (!busy_ff && !$past(busy_ff) |-> scl_ff && !sda_oe_ff)
    else $error("bus not released while idle");

  AST_IDLE_START:
    assert property ($rose(st_ff == ewm_pkg::ST_START) && first_ff |-> $past(sda_q) && $past(scl_ff))
    else $error("start issued on busy bus");

  AST_START_SEQ:
    assert property (s_start |-> sda_oe_ff throughout (##[1:AST_QMAX] !scl_ff))
    else $error("start not followed by clock low with data held");

  AST_STOP_END:
    assert property (s_stop |-> ##[1:AST_SPAN] !busy_ff)
    else $error("stop not followed by idle");

  AST_SAMPLE_HIGH:
    assert property (tick && q_ff == 2'd2 && (st_ff == ewm_pkg::ST_TXACK || st_ff == ewm_pkg::ST_RXBIT)
                     |-> scl_ff && $past(scl_ff, 4))
    else $error("bit sampled outside clock high");

  AST_ACK_RELEASE:
    assert property (st_ff == ewm_pkg::ST_TXACK && q_ff == 2'd2 |-> !sda_oe_ff && scl_ff)
    else $error("ninth pulse missing or data not released");

  AST_NACK_STOPS:
    assert property (st_ff == ewm_pkg::ST_TXACK && qend && ack_ff
                     |=> st_ff == ewm_pkg::ST_STOP && nack_pls_ff)
    else $error("missing ack did not end transfer");

  AST_READ_NOACK:
    assert property (st_ff == ewm_pkg::ST_RXACK && (q_ff == 2'd1 || q_ff == 2'd2) |-> !sda_oe_ff)
    else $error("host acked last read byte");

endmodule : ewm_ctrl

// [rtl/ewm_defs.svh]
// Purpose: offsets, field positions, reset values and timing counts of the wire master
// Assumes: core clock of 4 ns, bus clock near 400 kHz
// Notes:   byte addresses on the command port, one 32-bit word per register
`ifndef EWM_DEFS_SVH
`define EWM_DEFS_SVH

`define EWM_OFF_CTRL         8'h00
`define EWM_OFF_SEL          8'h04
`define EWM_OFF_WADDR        8'h08
`define EWM_OFF_WDATA        8'h0C
`define EWM_OFF_RDATA        8'h10
`define EWM_OFF_STATUS       8'h14

`define EWM_CTRL_GO          0
`define EWM_CTRL_OP_LO       1
`define EWM_CTRL_OP_HI       2

`define EWM_SEL_BLOCK        0
`define EWM_SEL_CS_LOW       1
`define EWM_SEL_CS_HIGH      2
`define EWM_SEL_WP           3

`define EWM_STAT_BUSY        0
`define EWM_STAT_DONE        1
`define EWM_STAT_NACK        2

`define EWM_SEL_RESET        4'h0
`define EWM_DEV_TYPE_DEFAULT 4'h5

`define EWM_CLK_PERIOD_NS    4
`define EWM_T_QUARTER_NS     625
`define EWM_QUARTER_CYC      ((`EWM_T_QUARTER_NS + `EWM_CLK_PERIOD_NS - 1) / `EWM_CLK_PERIOD_NS)

`endif

// [rtl/ewm_pkg.sv]
// Purpose: types shared by the wire master files
// Assumes: nothing beyond the defs header
// Notes:   operations are single-byte transfers
package ewm_pkg;

  typedef enum logic [1:0] {
    EWM_OP_WRITE,
    EWM_OP_RAND_READ,
    EWM_OP_CUR_READ,
    EWM_OP_POLL
  } ewm_op_t;

  typedef struct packed {
    logic wp;
    logic cs_high;
    logic cs_low;
    logic block;
  } ewm_sel_t;

  typedef struct packed {
    ewm_op_t     op;
    ewm_sel_t    sel;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ewm_cmd_t;

  typedef struct packed {
    logic       busy;
    logic       done;
    logic       nack;
    logic [7:0] rdata;
  } ewm_stat_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BUSWAIT,
    ST_START,
    ST_TXBIT,
    ST_TXACK,
    ST_RXBIT,
    ST_RXACK,
    ST_STOP
  } ewm_state_t;

  typedef enum logic [2:0] {
    PH_CTRL_W,
    PH_AHI,
    PH_ALO,
    PH_DATA,
    PH_RESTART,
    PH_CTRL_R,
    PH_READ,
    PH_END
  } ewm_phase_t;

endpackage : ewm_pkg

// [rtl/ewm_regs.sv]
// Purpose: command and status registers of the wire master
// Assumes: strobes are one cycle and never together
// Notes:   read data valid in the cycle after the read strobe only
`include "ewm_defs.svh"

module ewm_regs (
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic [7:0]        bus_addr_in,
  input  wire logic [31:0]       bus_wdata_in,
  input  wire logic              bus_wr_in,
  input  wire logic              bus_rd_in,
  output logic      [31:0]       bus_rdata_out,
  input  wire ewm_pkg::ewm_stat_t stat_in,
  output ewm_pkg::ewm_cmd_t      cmd_out,
  output logic                   go_out
);

  ewm_pkg::ewm_op_t  op_ff;
  ewm_pkg::ewm_sel_t sel_ff;
  logic [15:0]       addr_ff;
  logic [7:0]        wdata_ff;
  logic              go_ff;
  logic              done_ff;
  logic              nack_ff;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic              wr_ok;

  // settings freeze while a transfer runs so pins stay put on the wire;
  // the go cycle counts too, busy only rises one cycle after it
  assign wr_ok = bus_wr_in && !stat_in.busy && !go_ff;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      op_ff    <= ewm_pkg::EWM_OP_WRITE;
      sel_ff   <= `EWM_SEL_RESET;
      addr_ff  <= 16'h0000;
      wdata_ff <= 8'h00;
    end else if (wr_ok) begin
      case (bus_addr_in)
        `EWM_OFF_CTRL:  op_ff    <= ewm_pkg::ewm_op_t'(bus_wdata_in[`EWM_CTRL_OP_HI:`EWM_CTRL_OP_LO]);
        `EWM_OFF_SEL:   sel_ff   <= bus_wdata_in[3:0];
        `EWM_OFF_WADDR: addr_ff  <= bus_wdata_in[15:0];
        `EWM_OFF_WDATA: wdata_ff <= bus_wdata_in[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      go_ff <= 1'b0;
    end else begin
      go_ff <= wr_ok && (bus_addr_in == `EWM_OFF_CTRL) && bus_wdata_in[`EWM_CTRL_GO];
    end
  end

  // set beats clear on sticky flags
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else begin
      if (stat_in.done) begin
        done_ff <= 1'b1;
      end else if (go_ff) begin
        done_ff <= 1'b0;
      end
      if (stat_in.nack) begin
        nack_ff <= 1'b1;
      end else if (go_ff) begin
        nack_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (bus_addr_in)
      `EWM_OFF_CTRL:   nxt_rdata = {29'h0000_0000, op_ff, 1'b0};
      `EWM_OFF_SEL:    nxt_rdata = {28'h000_0000, sel_ff};
      `EWM_OFF_WADDR:  nxt_rdata = {16'h0000, addr_ff};
      `EWM_OFF_WDATA:  nxt_rdata = {24'h00_0000, wdata_ff};
      `EWM_OFF_RDATA:  nxt_rdata = {24'h00_0000, stat_in.rdata};
      `EWM_OFF_STATUS: nxt_rdata = {29'h0000_0000, nack_ff, done_ff, stat_in.busy};
      default:         nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= bus_rd_in ? nxt_rdata : 32'h0000_0000;
    end
  end

  assign bus_rdata_out = rdata_ff;
  assign go_out        = go_ff;
  assign cmd_out       = '{op: op_ff, sel: sel_ff, addr: addr_ff, wdata: wdata_ff};

endmodule : ewm_regs

// [rtl/ewm_sync.sv]
// Purpose: three-stage synchroniser for a pin
// Assumes: input is asynchronous to core_clk_in
// Notes:   output moves only when stages two and three agree
module ewm_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic d_in,
  output logic      q_out
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
    end else begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a lone disagreement is treated as a glitch
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      q_ff <= RESET_VAL;
    end else if (s2_ff == s3_ff) begin
      q_ff <= s3_ff;
    end
  end

  assign q_out = q_ff;

endmodule : ewm_sync

// [verif/ewm_ctrl_bench.sv]
// Purpose: self-checking bench for the wire master
// Assumes: quarter shortened to 8 core cycles
// Notes:   the model's low select pin can be flipped to force a mismatch
`include "ewm_defs.svh"
module ewm_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr_s, rd_s, rd_d, flip, oe, mem_oe, sda;
  logic        scl, cs_lo, cs_hi, fix, wp, sdo;
  logic [7:0]  addr;
  logic [15:0] a;
  logic [31:0] wdata, rdata, last, d;
  logic [63:0] nt;
  logic [63:0] q [$];
  int          errors, comparisons, seed;
  assign sda = ~(oe | mem_oe);
  ewm_ctrl #(.QUARTER_CYC(8), .DEV_TYPE(4'h6)) ewm_ctrl_i ( // arbitrary type code
    .core_clk_in(clk), .rst_in(rst), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_wr_in(wr_s), .bus_rd_in(rd_s), .bus_rdata_out(rdata), .scl_out(scl),
    .sda_in(sda), .sda_out(sdo), .sda_oe_out(oe), .chip_select_pin_low_out(cs_lo),
    .chip_select_pin_high_out(cs_hi), .fixed_select_pin_out(fix), .write_protect_out(wp));
  ewm_mem_model #(.TYPE_CODE(4'h6), .BUSY_POLLS(2)) ewm_mem_model_i (
    .scl_in(scl), .sda_in(sda), .cs_low_in(cs_lo ^ flip), .cs_high_in(cs_hi),
    .wp_in(wp), .sda_oe_out(mem_oe));
  always #2 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk);
    addr <= ad;
    wdata <= dt;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  // mask of zero notes a read whose value is not compared
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= ad;
    rd_s <= 1'b1;
    q.push_back({e, m});
    @(posedge clk);
    rd_s <= 1'b0;
  endtask : rd
  task automatic run(input logic [1:0] op, input logic [31:0] st);
    int n;
    wr(`EWM_OFF_CTRL, {29'h0, op, 1'b1});
    // lands while busy, so it must be ignored; a later read at the old address shows it
    wr(`EWM_OFF_WADDR, 32'h0000_0000);
    last = 32'h0000_0001;
    for (n = 0; n < 1000 && last[0] !== 1'b0; n++) rd(`EWM_OFF_STATUS, 32'h0, 32'h0);
    rd(`EWM_OFF_STATUS, st, 32'h0000_0007);
  endtask : run
  always @(posedge clk) begin
    rd_d <= rd_s;
    if (rd_d === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      last = rdata;
      if (nt[31:0] !== 32'h0) check(rdata & nt[31:0], nt[63:32]);
    end
  end
  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // full run needs about 10000 cycles; five times that is a hang
  initial begin
    #200000;
    errors++;
    final_report();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    flip = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    errors = 0;
    comparisons = 0;
    seed = 41609;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({28'h0, sdo, scl, oe, fix}, 32'h0000_0005);
    rd(`EWM_OFF_SEL, 32'h0, 32'hffff_ffff);
    rd(8'h20, 32'h0, 32'hffff_ffff);
    $display("test reset done");
    a = (16'($random(seed)) & 16'hff7f) | 16'h0001;
    d = $random(seed) & 32'h0000_00ff;
    wr(`EWM_OFF_SEL, 32'h0000_0005);
    wr(`EWM_OFF_WADDR, {16'h0, a});
    wr(`EWM_OFF_WDATA, d);
    run(2'd0, 32'h0000_0002);
    check({29'h0, wp, cs_hi, cs_lo}, 32'h0000_0002);
    repeat (2) run(2'd3, 32'h0000_0006);
    run(2'd3, 32'h0000_0002);
    run(2'd1, 32'h0000_0002);
    rd(`EWM_OFF_RDATA, d, 32'hffff_ffff);
    $display("test write and poll done");
    wr(`EWM_OFF_SEL, 32'h0000_000d);
    wr(`EWM_OFF_WDATA, ~d & 32'h0000_00ff);
    run(2'd0, 32'h0000_0002);
    check({31'h0, wp}, 32'h0000_0001);
    wr(`EWM_OFF_SEL, 32'h0000_0005);
    run(2'd1, 32'h0000_0002);
    rd(`EWM_OFF_RDATA, d, 32'hffff_ffff);
    $display("test write protect done");
    wr(`EWM_OFF_WADDR, 32'h0000_ffff);
    run(2'd1, 32'h0000_0002);
    rd(`EWM_OFF_RDATA, 32'h0000_003c, 32'hffff_ffff);
    run(2'd2, 32'h0000_0002);
    rd(`EWM_OFF_RDATA, 32'h0000_00c3, 32'hffff_ffff);
    $display("test block boundary done");
    flip <= 1'b1;
    run(2'd3, 32'h0000_0006);
    run(2'd2, 32'h0000_0006);
    flip <= 1'b0;
    run(2'd3, 32'h0000_0002);
    $display("test select mismatch done");
    final_report();
  end
endmodule : ewm_ctrl_bench

// [verif/ewm_mem_model.sv]
// Purpose: behavioural serial memory on the far side of the wire master
// Assumes: scl push-pull from the host, pull-up on sda
// Notes:   256 bytes per half, aliased; busy lasts a fixed number of polls
module ewm_mem_model #(
  parameter logic [3:0] TYPE_CODE  = 4'h6, // arbitrary value
  parameter int         BUSY_POLLS = 2
) (
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic cs_low_in,
  input  wire logic cs_high_in,
  input  wire logic wp_in,
  output logic      sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:511];
  logic [7:0]  sh;
  logic [7:0]  wdat;
  logic [15:0] ptr;
  logic        act;
  logic        tx;
  logic        blk;
  logic        pend;
  int          cnt;
  int          nbyte;
  int          busy;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ (i > 255 ? 8'hc3 : 8'h5a);
    sda_oe_out = 1'b0;
    act = 1'b0;
    pend = 1'b0;
    busy = 0;
  end
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    act = 1'b1;
    tx = 1'b0;
    cnt = 0;
    nbyte = 0;
    sda_oe_out = 1'b0;
  end
  always @(posedge sda_in) if (scl_in === 1'b1) begin
    act = 1'b0;
    if (pend && !wp_in) begin
      mem[{blk, ptr[7:0]}] = wdat;
      busy = BUSY_POLLS;
    end
    pend = 1'b0;
  end
  always @(posedge scl_in) if (act) begin
    sh = tx ? sh : {sh[6:0], sda_in};
    cnt = cnt + 1;
    if (tx && cnt == 9 && sda_in) act = 1'b0;
  end
  // all drive changes on the falling clock, never while high
  always @(negedge scl_in) if (act) begin
    if (cnt == 8 && tx) sda_oe_out = 1'b0;
    else if (cnt == 8) begin
      sda_oe_out = 1'b1;
      if (nbyte == 0) begin
        if (sh[7:4] != TYPE_CODE || sh[2:1] != {cs_high_in, cs_low_in} || busy > 0) begin
          sda_oe_out = 1'b0;
          act = 1'b0;
          busy = busy > 0 ? busy - 1 : 0;
        end
        blk = sh[3];
        tx = sh[0];
      end
      if (nbyte == 1) ptr[15:8] = sh;
      if (nbyte == 2) ptr[7:0] = sh;
      if (nbyte == 3) pend = 1'b1;
      if (nbyte == 3) wdat = sh;
      nbyte = nbyte + 1;
    end else if (cnt == 9) begin
      cnt = 0;
      sh = mem[{blk, ptr[7:0]}];
      sda_oe_out = tx & !sh[7];
      if (tx) ptr = ptr + 16'h0001;
    end else if (tx) begin
      sh = sh << 1;
      sda_oe_out = !sh[7];
    end
  end
endmodule : ewm_mem_model
